// *** logic/cwf_pkg.sv ***
// Constants, types and helpers for the continuous weight frame transmitter
package cwf_pkg;
  localparam logic [7:0]  STX_CODE    = 8'h02;
  localparam logic [7:0]  CR_CODE     = 8'h0D;
  localparam logic [7:0]  SPACE_CODE  = 8'h20;
  localparam logic [7:0]  DIGIT_BASE  = 8'h30;
  localparam logic [7:0]  XON_CODE    = 8'h11;
  localparam logic [7:0]  XOFF_CODE   = 8'h13;
  localparam logic [9:0]  IDX_CR      = 10'h010;
  localparam logic [9:0]  IDX_CHK     = 10'h011;
  localparam logic [9:0]  IDX_RST     = 10'h000;
  localparam int          DIGITS      = 6;
  localparam int          TPL_SLOTS   = 5;
  localparam logic [9:0]  TPL_MAX     = 10'h3E8;
  localparam int          TPL_AW      = 13;
  localparam int          TPL_DEPTH   = 8192;
  localparam int          CLK_NS      = 10;
  localparam int          MS_NS       = 1_000_000;
  localparam int          MS_CYCLES   = MS_NS / CLK_NS;
  localparam logic [3:0]  BAUD_MAX    = 4'h9;
  localparam logic [10:0] MS_SAT      = 11'h7FF;
  localparam logic [10:0] STD_MS [10] = '{11'h1F4, 11'h0FA, 11'h07D, 11'h064, 11'h032,
                                          11'h032, 11'h032, 11'h032, 11'h032, 11'h032};
  localparam logic [10:0] TPL_MS [10] = '{11'h3E8, 11'h1F4, 11'h0FA, 11'h0A7, 11'h07D,
                                          11'h064, 11'h053, 11'h047, 11'h03E, 11'h037};

  typedef enum logic [2:0] {ST_IDLE, ST_STD, ST_TRD, ST_TWT, ST_TSEND} cwf_state_t;

  // Digit or blank as an ASCII character
  function automatic logic [7:0] cwf_char(input logic [3:0] d, input logic blank);
    cwf_char = blank ? SPACE_CODE : (DIGIT_BASE | {4'h0, d});
  endfunction : cwf_char
endpackage : cwf_pkg

// *** logic/cwf_tpl_if.sv ***
// Template memory port between frame logic and storage
interface cwf_tpl_if;
  logic                      wr_en;
  logic [cwf_pkg::TPL_AW-1:0] wr_addr;
  logic [7:0]                wr_data;
  logic [cwf_pkg::TPL_AW-1:0] rd_addr;
  logic [7:0]                rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : cwf_tpl_if

// *** logic/cwf_tpl_mem.sv ***
// Template byte store with registered read data
module cwf_tpl_mem #(
  parameter int DEPTH = cwf_pkg::TPL_DEPTH
) (
  input wire logic mclk,
  cwf_tpl_if.mem   port
);
  logic [7:0] store [DEPTH];
  logic [7:0] rd_q;

  always_ff @(posedge mclk) begin
    if (port.wr_en) begin
      store[port.wr_addr] <= port.wr_data;
    end
    rd_q <= store[port.rd_addr];
  end

  assign port.rd_data = rd_q;
endmodule : cwf_tpl_mem

// *** logic/cwf_tx.sv ***
// Continuous weight frame transmitter top
// Summary of operation
// - Each standard frame opens with start-of-text 0x02.
// - Order: start, three status bytes, six weight, six tare, CR, checksum.
// - Non-significant weight and tare digits go out as spaces.
// - Frame layout fixed; only rate, parity, flow control, interface vary.
// - Checksum byte appended only when enabled; else frame ends at CR.
// - First status bits 2..0 give decimal point position.
// - Second status bit 0 net, bit 1 negative.
// - Second status bit 2 out of range, bit 3 motion.
// - Second status bit 4 kilograms, bit 5 one, bit 6 zero not captured.
// - Third status bits 2..0 unit code; tons and custom share 111.
// - About 20 frames per second at 4800 baud and above, two at 300.
// - An output rate setting overrides the default repetition rate.
// - Template mode repeats one of five selectable templates.
// - Template rate follows baud, about 1 to 18 per second.
// - Template storage holds encoded field references as plain bytes.
// - Templates are limited to 1000 bytes.
// - XOFF 0x13 pauses transmission, XON 0x11 resumes it.
// - Characters are seven or eight data bits, baud 300 to 115200.
module cwf_tx #(
  parameter int MS_CYCLES = cwf_pkg::MS_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic [23:0] weight_bcd,
  input  wire logic [23:0] tare_bcd,
  input  wire logic [2:0]  dp_code,
  input  wire logic [1:0]  build_code,
  input  wire logic        is_net,
  input  wire logic        is_negative,
  input  wire logic        out_of_range,
  input  wire logic        in_motion,
  input  wire logic        unit_kg,
  input  wire logic        zero_not_captured,
  input  wire logic [2:0]  unit_code,
  input  wire logic        print_request,
  input  wire logic        expand_x10,
  input  wire logic [3:0]  baud_sel,
  input  wire logic        data_eight,
  input  wire logic        checksum_en,
  input  wire logic        rate_override_en,
  input  wire logic [10:0] output_rate_setting,
  input  wire logic        cont_enable,
  input  wire logic        template_mode,
  input  wire logic [2:0]  tpl_sel,
  input  wire logic [9:0]  tpl_len,
  input  wire logic        tpl_wr_en,
  input  wire logic [2:0]  tpl_wr_slot,
  input  wire logic [9:0]  tpl_wr_addr,
  input  wire logic [7:0]  tpl_wr_data,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        tx_ready,
  output logic             tx_valid,
  output logic      [7:0]  tx_data,
  output logic             flow_paused,
  output logic             frame_busy
);
  localparam int MSW = $clog2(MS_CYCLES + 1);
  localparam logic [MSW-1:0] MS_LAST = MSW'(MS_CYCLES - 1);

  logic                rst_meta, rst_n;
  cwf_pkg::cwf_state_t state, next_state;
  logic [9:0]          idx, next_idx;
  logic [7:0]          cur, next_cur;
  logic [6:0]          sum, next_sum;
  logic                paused, next_paused;
  logic [MSW-1:0]      ms_cnt, next_ms_cnt;
  logic [10:0]         elapsed, next_elapsed;
  logic [23:0]         snap_w, snap_t, next_snap_w, next_snap_t;
  logic [7:0]          snap_a, snap_b, snap_c, next_snap_a, next_snap_b, next_snap_c;
  logic [2:0]          snap_dp, next_snap_dp, slot, next_slot;
  logic [9:0]          len, next_len;
  logic                snap_chk, next_snap_chk;
  logic [10:0]         period;
  logic [3:0]          baud;
  logic [9:0]          tpl_lim;
  logic                fire, start;
  cwf_tpl_if           tpl ();

  cwf_tpl_mem u_mem (.mclk(mclk), .port(tpl.mem));

  // Reset release synchroniser
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Blank leading zeros left of the digits that must show
  function automatic logic [7:0] digit_out(input logic [23:0] v, input int i);
    logic lead;
    int   shown;
    lead  = 1'b1;
    shown = (snap_dp > 3'h2) ? (int'(snap_dp) - 1) : 1;
    for (int k = 0; k <= i; k++) begin
      if (v[23-4*k -: 4] != 4'h0) begin
        lead = 1'b0;
      end
    end
    digit_out = cwf_pkg::cwf_char(v[23-4*i -: 4], lead && (i < cwf_pkg::DIGITS - shown));
  endfunction : digit_out

  // Fixed byte layout of the standard frame
  function automatic logic [7:0] std_byte(input logic [9:0] i, input logic [6:0] s);
    if (i == 10'h000) begin
      std_byte = cwf_pkg::STX_CODE;
    end else if (i == 10'h001) begin
      std_byte = snap_a;
    end else if (i == 10'h002) begin
      std_byte = snap_b;
    end else if (i == 10'h003) begin
      std_byte = snap_c;
    end else if (i < 10'h00A) begin
      std_byte = digit_out(snap_w, int'(i) - 4);
    end else if (i < cwf_pkg::IDX_CR) begin
      std_byte = digit_out(snap_t, int'(i) - 10);
    end else if (i == cwf_pkg::IDX_CR) begin
      std_byte = cwf_pkg::CR_CODE;
    end else begin
      std_byte = {1'b0, 7'(-s)};
    end
  endfunction : std_byte

  // Seven-bit characters drop the top bit
  function automatic logic [7:0] char_fmt(input logic [7:0] b);
    char_fmt = data_eight ? b : {1'b0, b[6:0]};
  endfunction : char_fmt

  assign baud     = (baud_sel > cwf_pkg::BAUD_MAX) ? cwf_pkg::BAUD_MAX : baud_sel;
  assign tpl_lim  = (tpl_len > cwf_pkg::TPL_MAX) ? cwf_pkg::TPL_MAX : tpl_len;
  assign period   = (rate_override_en && output_rate_setting != 11'h000) ? output_rate_setting
                  : template_mode ? cwf_pkg::TPL_MS[baud]
                  : cwf_pkg::STD_MS[baud];
  assign tx_valid = (state == cwf_pkg::ST_STD || state == cwf_pkg::ST_TSEND) && !paused;
  assign fire     = tx_valid && tx_ready;
  assign start    = state == cwf_pkg::ST_IDLE && cont_enable && elapsed >= period;
  assign tx_data  = cur;
  assign flow_paused = paused;
  assign frame_busy  = state != cwf_pkg::ST_IDLE;

  // Template storage; stored codes count byte for byte against the budget
  assign tpl.wr_en   = tpl_wr_en && tpl_wr_slot < 3'(cwf_pkg::TPL_SLOTS)
                     && tpl_wr_addr < cwf_pkg::TPL_MAX;
  assign tpl.wr_addr = {tpl_wr_slot, tpl_wr_addr};
  assign tpl.wr_data = tpl_wr_data;
  assign tpl.rd_addr = {slot, idx};

  always_comb begin
    next_state    = state;
    next_idx      = idx;
    next_cur      = cur;
    next_sum      = sum;
    next_paused   = paused;
    next_snap_w   = snap_w;
    next_snap_t   = snap_t;
    next_snap_a   = snap_a;
    next_snap_b   = snap_b;
    next_snap_c   = snap_c;
    next_snap_dp  = snap_dp;
    next_snap_chk = snap_chk;
    next_slot     = slot;
    next_len      = len;
    next_ms_cnt   = (ms_cnt == MS_LAST) ? '0 : ms_cnt + 1'b1;
    next_elapsed  = (ms_cnt == MS_LAST && elapsed != cwf_pkg::MS_SAT) ? elapsed + 11'h001
                  : elapsed;
    if (rx_valid && rx_data == cwf_pkg::XOFF_CODE) begin
      next_paused = 1'b1;
    end else if (rx_valid && rx_data == cwf_pkg::XON_CODE) begin
      next_paused = 1'b0;
    end
    case (state)
      cwf_pkg::ST_IDLE: begin
        if (start) begin
          next_elapsed = 11'h000;
          next_idx     = cwf_pkg::IDX_RST;
          next_sum     = 7'h00;
          if (template_mode) begin
            next_slot = tpl_sel;
            next_len  = tpl_lim;
            if (tpl_sel < 3'(cwf_pkg::TPL_SLOTS) && tpl_lim != 10'h000) begin
              next_state = cwf_pkg::ST_TRD;
            end
          end else begin
            next_snap_w   = weight_bcd;
            next_snap_t   = tare_bcd;
            next_snap_dp  = dp_code;
            next_snap_chk = checksum_en;
            next_snap_a   = {2'b00, 1'b1, build_code, dp_code};
            next_snap_b   = {1'b0, zero_not_captured, 1'b1, unit_kg,
                             in_motion, out_of_range,
                             is_negative, is_net};
            next_snap_c   = {2'b00, 1'b1, expand_x10, print_request,
                             unit_code};
            next_cur      = cwf_pkg::STX_CODE;
            next_state    = cwf_pkg::ST_STD;
          end
        end
      end
      cwf_pkg::ST_STD: begin
        if (fire) begin
          next_sum = sum + cur[6:0];
          if (idx == (snap_chk ? cwf_pkg::IDX_CHK : cwf_pkg::IDX_CR)) begin
            next_state = cwf_pkg::ST_IDLE;
          end else begin
            next_idx = idx + 10'h001;
            next_cur = char_fmt(std_byte(idx + 10'h001, sum + cur[6:0]));
          end
        end
      end
      cwf_pkg::ST_TRD: begin
        next_state = cwf_pkg::ST_TWT;
      end
      cwf_pkg::ST_TWT: begin
        next_cur   = char_fmt(tpl.rd_data);
        next_state = cwf_pkg::ST_TSEND;
      end
      cwf_pkg::ST_TSEND: begin
        if (fire) begin
          next_idx   = idx + 10'h001;
          next_state = (idx + 10'h001 == len) ? cwf_pkg::ST_IDLE : cwf_pkg::ST_TRD;
        end
      end
      default: begin
        next_state = cwf_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= cwf_pkg::ST_IDLE;
      idx      <= cwf_pkg::IDX_RST;
      cur      <= 8'h00;
      sum      <= 7'h00;
      paused   <= 1'b0;
      ms_cnt   <= '0;
      elapsed  <= 11'h000;
      snap_w   <= 24'h00_0000;
      snap_t   <= 24'h00_0000;
      snap_a   <= 8'h00;
      snap_b   <= 8'h00;
      snap_c   <= 8'h00;
      snap_dp  <= 3'h0;
      snap_chk <= 1'b0;
      slot     <= 3'h0;
      len      <= 10'h000;
    end else begin
      state    <= next_state;
      idx      <= next_idx;
      cur      <= next_cur;
      sum      <= next_sum;
      paused   <= next_paused;
      ms_cnt   <= next_ms_cnt;
      elapsed  <= next_elapsed;
      snap_w   <= next_snap_w;
      snap_t   <= next_snap_t;
      snap_a   <= next_snap_a;
      snap_b   <= next_snap_b;
      snap_c   <= next_snap_c;
      snap_dp  <= next_snap_dp;
      snap_chk <= next_snap_chk;
      slot     <= next_slot;
      len      <= next_len;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_STX_FIRST: assert property (start && !template_mode |=> tx_data == cwf_pkg::STX_CODE)
    else $error("frame did not open with start code");
  AST_CR_SLOT: assert property (state == cwf_pkg::ST_STD && idx == cwf_pkg::IDX_CR
    |-> tx_data == cwf_pkg::CR_CODE)
    else $error("carriage return missing at byte 17");
  AST_FRAME_END: assert property (state == cwf_pkg::ST_STD && fire && idx == cwf_pkg::IDX_CR
    && !snap_chk |=> state == cwf_pkg::ST_IDLE)
    else $error("frame did not end at carriage return");
  AST_LEAD_SPACE: assert property (state == cwf_pkg::ST_STD && idx == 10'h004
    && snap_w[23:20] == 4'h0 && snap_dp != 3'h7 |-> tx_data == cwf_pkg::SPACE_CODE)
    else $error("leading zero not blanked");
  AST_STATUS_A: assert property (state == cwf_pkg::ST_STD && idx == 10'h001
    |-> tx_data[6:5] == 2'b01 && tx_data[2:0] == snap_dp)
    else $error("first status byte malformed");
  AST_STATUS_B: assert property (state == cwf_pkg::ST_STD && idx == 10'h002
    |-> tx_data[5] == 1'b1)
    else $error("second status byte fixed bit wrong");
  AST_STATUS_C: assert property (state == cwf_pkg::ST_STD && idx == 10'h003
    |-> tx_data[6:5] == 2'b01)
    else $error("third status byte fixed bits wrong");
  AST_CHECKSUM: assert property (state == cwf_pkg::ST_STD && idx == cwf_pkg::IDX_CHK
    |-> 7'(sum + tx_data[6:0]) == 7'h00)
    else $error("checksum does not zero the frame sum");
  AST_XOFF_HOLD: assert property (rx_valid && rx_data == cwf_pkg::XOFF_CODE
    |=> !tx_valid)
    else $error("transmit continued after XOFF");
  AST_TPL_LIMIT: assert property (state == cwf_pkg::ST_TSEND |-> idx < cwf_pkg::TPL_MAX)
    else $error("template byte beyond storage budget");
  AST_SEVEN_BIT: assert property (tx_valid && !data_eight |-> !tx_data[7])
    else $error("eighth bit sent in seven-bit mode");

  COV_STD_CHK: cover property (state == cwf_pkg::ST_STD && fire && idx == cwf_pkg::IDX_CHK);
  COV_TPL_DONE: cover property (state == cwf_pkg::ST_TSEND && fire ##1 state == cwf_pkg::ST_IDLE);
  COV_PAUSE: cover property (paused && state == cwf_pkg::ST_STD ##1 !paused);
  COV_OVERRIDE: cover property (start && rate_override_en);
endmodule : cwf_tx

// *** dv/cwf_remote_rx.sv ***
// Remote receiver model: takes frame bytes and sends flow control codes
module cwf_remote_rx (
  input  wire logic       mclk,
  input  wire logic       slow,
  input  wire logic       pause_req,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            got_valid,
  output logic      [7:0] got_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pause_seen = 1'b0;

  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h5A;
    got_valid = 1'b0;
    got_byte = 8'h00;
  end

  always @(posedge mclk) begin
    got_valid <= tx_valid && tx_ready;
    if (tx_valid && tx_ready) begin
      got_byte <= tx_data;
    end
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (pause_req != pause_seen) begin
      rx_valid <= 1'b1;
      rx_data  <= pause_req ? cwf_pkg::XOFF_CODE : cwf_pkg::XON_CODE;
    end else begin
      rx_valid <= 1'b0;
      rx_data  <= ~rx_data;
    end
    pause_seen <= pause_req;
  end
endmodule : cwf_remote_rx

// *** dv/test_continuous_weight_frame_tx.sv ***
// Self-checking bench for the continuous weight frame transmitter
module test_continuous_weight_frame_tx;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0, nrst = 1'b0, slow = 1'b0, pause_req = 1'b0;
  logic [23:0] weight_bcd = '0, tare_bcd = '0;
  logic [2:0]  dp_code = '0, unit_code = '0, tpl_sel = '0, tpl_wr_slot = '0;
  logic [1:0]  build_code = 2'h1;
  logic        is_net = 0, is_negative = 0, out_of_range = 0, in_motion = 0, unit_kg = 0;
  logic        zero_not_captured = 0, print_request = 0, expand_x10 = 0, data_eight = 1;
  logic        checksum_en = 0, rate_override_en = 0, cont_enable = 1, template_mode = 0;
  logic [3:0]  baud_sel = 4'h9;
  logic [10:0] output_rate_setting = '0;
  logic [9:0]  tpl_len = '0, tpl_wr_addr = '0;
  logic        tpl_wr_en = 0, rx_valid, tx_ready, tx_valid, flow_paused, frame_busy, got_valid;
  logic [7:0]  tpl_wr_data = '0, rx_data, tx_data, got_byte;
  logic [7:0]  seen [$];
  logic [7:0]  exp_b [18];
  int          fails = 0, num_checks = 0, cyc = 0, last_rise = 0, gap = 0;
  logic        prev_busy = 1'b0;

  cwf_tx #(.MS_CYCLES(10)) dut (.mclk, .nrst, .weight_bcd, .tare_bcd, .dp_code, .build_code,
    .is_net, .is_negative, .out_of_range, .in_motion, .unit_kg, .zero_not_captured,
    .unit_code, .print_request, .expand_x10, .baud_sel, .data_eight, .checksum_en,
    .rate_override_en, .output_rate_setting, .cont_enable, .template_mode, .tpl_sel,
    .tpl_len, .tpl_wr_en, .tpl_wr_slot, .tpl_wr_addr, .tpl_wr_data, .rx_valid, .rx_data,
    .tx_ready, .tx_valid, .tx_data, .flow_paused, .frame_busy);
  cwf_remote_rx far (.mclk, .slow, .pause_req, .tx_valid, .tx_data, .tx_ready, .rx_valid,
    .rx_data, .got_valid, .got_byte);

  initial begin
    forever #5 mclk = ~mclk;
  end

  // Byte collection and frame start spacing
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    prev_busy <= frame_busy;
    if (frame_busy === 1'b1 && prev_busy === 1'b0) begin
      gap <= cyc - last_rise;
      last_rise <= cyc;
    end
    if (got_valid === 1'b1) begin
      seen.push_back(got_byte);
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input string name, input logic [10:0] e, input logic [10:0] s);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", name, e, s);
    end
  endtask : chk

  task automatic wait_busy(input logic lvl);
    int t;
    t = 0;
    while (frame_busy !== lvl) begin
      @(posedge mclk);
      t++;
      if (t > 12000) begin
        fails++;
        $display("unexpected frame_busy wait: expected %b seen %b", lvl, frame_busy);
        results();
      end
    end
  endtask : wait_busy

  // Expected standard frame from the inputs now applied
  task automatic make_exp();
    int keep;
    logic lw, lt;
    logic [7:0] s;
    keep = (dp_code >= 3) ? int'(dp_code) - 1 : 1;
    exp_b[0] = cwf_pkg::STX_CODE;
    exp_b[1] = {3'b001, build_code, dp_code};
    exp_b[2] = {1'b0, zero_not_captured, 1'b1, unit_kg, in_motion, out_of_range,
                is_negative, is_net};
    exp_b[3] = {3'b001, expand_x10, print_request, unit_code};
    lw = 1'b1;
    lt = 1'b1;
    for (int i = 0; i < 6; i++) begin
      lw = lw && (weight_bcd[23-4*i -: 4] == 4'h0) && (i < 6 - keep);
      lt = lt && (tare_bcd[23-4*i -: 4] == 4'h0) && (i < 6 - keep);
      exp_b[4+i] = lw ? cwf_pkg::SPACE_CODE : {4'h3, weight_bcd[23-4*i -: 4]};
      exp_b[10+i] = lt ? cwf_pkg::SPACE_CODE : {4'h3, tare_bcd[23-4*i -: 4]};
    end
    exp_b[16] = cwf_pkg::CR_CODE;
    s = 8'h00;
    for (int i = 0; i < 17; i++) begin
      s = s + exp_b[i];
    end
    exp_b[17] = (8'h00 - s) & 8'h7F;
  endtask : make_exp

  task automatic grab(input int n, input logic hold);
    wait_busy(1'b0);
    wait_busy(1'b1);
    seen.delete();
    if (hold) begin
      repeat (4) @(posedge mclk);
      pause_req <= 1'b1;
      repeat (4) @(posedge mclk);
      chk("flow_paused", 11'h001, {10'h000, flow_paused});
      repeat (20) @(posedge mclk);
      chk("tx_valid paused", 11'h000, {10'h000, tx_valid});
      chk("frame_busy paused", 11'h001, {10'h000, frame_busy});
      pause_req <= 1'b0;
    end
    wait_busy(1'b0);
    repeat (3) @(posedge mclk);
    chk("frame length", 11'(n), 11'(seen.size()));
    for (int i = 0; i < n && i < seen.size(); i++) begin
      chk("frame byte", {3'h0, exp_b[i]}, {3'h0, seen[i]});
    end
  endtask : grab

  task automatic t_std(input logic hold);
    @(posedge mclk);
    weight_bcd <= 24'h00_1230;
    tare_bcd <= 24'h00_0000;
    dp_code <= 3'h4;
    build_code <= 2'h2;
    unit_code <= 3'h7;
    {is_net, is_negative, out_of_range, in_motion, unit_kg} <= 5'h1B;
    {zero_not_captured, print_request, expand_x10} <= 3'h7;
    checksum_en <= 1'b1;
    @(posedge mclk);
    make_exp();
    grab(18, hold);
    $display("test standard frame done");
  endtask : t_std

  task automatic t_codes();
    for (int k = 0; k < 8; k++) begin
      @(posedge mclk);
      slow <= 1'b1;
      checksum_en <= 1'b0;
      dp_code <= 3'(k);
      unit_code <= 3'(k);
      build_code <= 2'(k % 3 + 1);
      weight_bcd <= 24'h00_0000 + 24'(k * 24'h01_0101);
      {is_net, is_negative, out_of_range, in_motion, unit_kg} <= 5'(k * 5);
      {zero_not_captured, print_request, expand_x10} <= 3'(k);
      @(posedge mclk);
      make_exp();
      grab(17, 1'b0);
    end
    slow <= 1'b0;
    $display("test status codes done");
  endtask : t_codes

  task automatic rate_case(input logic [3:0] b, input logic ov, input logic [10:0] ms,
                           input int e);
    @(posedge mclk);
    baud_sel <= b;
    rate_override_en <= ov;
    output_rate_setting <= ms;
    repeat (3) begin
      wait_busy(1'b1);
      wait_busy(1'b0);
    end
    num_checks++;
    if (gap < e - 2 || gap > e + 2) begin
      fails++;
      $display("unexpected frame period: expected %0d seen %0d", e, gap);
    end
    $display("test frame rate done");
  endtask : rate_case

  task automatic t_tpl();
    logic [7:0] tb [3] = '{8'hC1, 8'h42, 8'h0D};
    for (int a = 0; a < 3; a++) begin
      @(posedge mclk);
      tpl_wr_en <= 1'b1;
      tpl_wr_slot <= 3'h2;
      tpl_wr_addr <= 10'(a);
      tpl_wr_data <= tb[a];
      exp_b[a] = tb[a] & 8'h7F;
    end
    @(posedge mclk);
    tpl_wr_en <= 1'b0;
    tpl_sel <= 3'h2;
    tpl_len <= 10'h003;
    data_eight <= 1'b0;
    template_mode <= 1'b1;
    @(posedge mclk);
    grab(3, 1'b0);
    $display("test template done");
  endtask : t_tpl

  // No frame may start for n cycles under the settings now applied
  task automatic quiet(input string name, input int n);
    int hits;
    hits = 0;
    repeat (2) @(posedge mclk);
    wait_busy(1'b0);
    repeat (n) begin
      @(posedge mclk);
      if (frame_busy !== 1'b0) begin
        hits++;
      end
    end
    chk(name, 11'h000, 11'(hits));
  endtask : quiet

  task automatic t_quiet();
    tpl_sel <= 3'h5;
    quiet("frames from slot 5", 1200);
    template_mode <= 1'b0;
    cont_enable <= 1'b0;
    quiet("frames while disabled", 1200);
    cont_enable <= 1'b1;
    $display("test refused start done");
  endtask : t_quiet

  initial begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    t_std(1'b0);
    t_codes();
    t_std(1'b1);
    rate_case(4'h4, 1'b0, 11'h000, 500);
    rate_case(4'h0, 1'b0, 11'h000, 5000);
    rate_case(4'h9, 1'b1, 11'h014, 200);
    rate_case(4'h9, 1'b0, 11'h000, 500);
    rate_case(4'hC, 1'b0, 11'h000, 500);
    t_tpl();
    t_quiet();
    results();
  end
endmodule : test_continuous_weight_frame_tx
